// file: rtl/reorder_cfg.svh
// Offsets, field positions, reset values and table constants for the tap reorder block
`ifndef REORDER_CFG_SVH
`define REORDER_CFG_SVH
`define OFS_CTRL        12'h000
`define OFS_WIDTH       12'h004
`define OFS_HEIGHT      12'h008
`define OFS_STATUS      12'h00c
`define OFS_LAYOUT      12'h010
`define CTRL_ENABLE_BIT 0
`define CTRL_LINESCAN_BIT 1
`define CTRL_VANTAGE_LSB 2
`define CTRL_RESET      32'h0000_0000
`define WIDTH_RESET     16'h0400
`define HEIGHT_RESET    16'h0300
`define LAYOUT_RESET    4'h0
`define MAX_TAPS        3
`endif

// file: rtl/reorder_pkg.sv
// Types shared by the tap reorder block
package reorder_pkg;
  // Supported layouts (one, two and three taps)
  typedef enum logic [3:0] {
    LAYOUT_1X     = 4'h0,
    LAYOUT_1X2    = 4'h1,
    LAYOUT_2X     = 4'h2,
    LAYOUT_2XE    = 4'h3,
    LAYOUT_2XM    = 4'h4,
    LAYOUT_1X_1Y2 = 4'h5,
    LAYOUT_1X_2YE = 4'h6,
    LAYOUT_1X3    = 4'h7,
    LAYOUT_3X     = 4'h8
  } tap_layout_code_e;
  typedef enum logic [1:0] {
    VANTAGE_TOP_LEFT     = 2'h0,
    VANTAGE_TOP_RIGHT    = 2'h1,
    VANTAGE_BOTTOM_LEFT  = 2'h2,
    VANTAGE_BOTTOM_RIGHT = 2'h3
  } vantage_e;
  typedef enum logic [1:0] {
    RUN_IDLE  = 2'h0,
    RUN_FRAME = 2'h1,
    RUN_DONE  = 2'h2
  } run_state_e;
  typedef logic [15:0] coord_t;
  typedef logic signed [16:0] step_t;
endpackage

// file: rtl/tap_descriptor.sv
// Per-tap geometry lookup for one tap of the selected layout
`timescale 1ns/10ps
`default_nettype none
module tap_descriptor (
  input  wire logic [3:0]  tap_layout_code,
  input  wire logic [1:0]  tap_index,
  input  wire logic [15:0] pixels_per_row,
  input  wire logic [15:0] rows_per_frame,
  output logic      [15:0] first_column,
  output logic      [15:0] last_column,
  output logic signed [16:0] column_increment,
  output logic      [15:0] first_row,
  output logic      [15:0] last_row,
  output logic signed [16:0] row_increment,
  output logic             tap_used
);
  logic [15:0] w;
  logic [15:0] h;
  logic [15:0] w2;
  logic [15:0] w3;
  logic [15:0] h2;
  assign w  = pixels_per_row;
  assign h  = rows_per_frame;
  assign w2 = w >> 1;
  assign w3 = w / 16'h0003;
  assign h2 = h >> 1;

  // Table of start, end and step per tap, relative to W and H
  always_comb begin
    first_column     = 16'h0001;
    last_column      = w;
    column_increment = 17'sh00001;
    first_row        = 16'h0001;
    last_row         = h;
    row_increment    = 17'sh00001;
    tap_used         = (tap_index == 2'h0);
    case (reorder_pkg::tap_layout_code_e'(tap_layout_code))
      reorder_pkg::LAYOUT_1X: begin
      end
      reorder_pkg::LAYOUT_1X2: begin
        tap_used         = (tap_index < 2'h2);
        first_column     = (tap_index == 2'h0) ? 16'h0001 : 16'h0002;
        last_column      = (tap_index == 2'h0) ? w - 16'h0001 : w;
        column_increment = 17'sh00002;
      end
      reorder_pkg::LAYOUT_2X: begin
        tap_used     = (tap_index < 2'h2);
        first_column = (tap_index == 2'h0) ? 16'h0001 : w2 + 16'h0001;
        last_column  = (tap_index == 2'h0) ? w2 : w;
      end
      reorder_pkg::LAYOUT_2XE: begin
        tap_used = (tap_index < 2'h2);
        if (tap_index == 2'h0) begin
          last_column = w2;
        end else begin
          first_column     = w;
          last_column      = w2 + 16'h0001;
          column_increment = -17'sh00001;
        end
      end
      reorder_pkg::LAYOUT_2XM: begin
        tap_used = (tap_index < 2'h2);
        if (tap_index == 2'h0) begin
          first_column     = w2;
          last_column      = 16'h0001;
          column_increment = -17'sh00001;
        end else begin
          first_column = w2 + 16'h0001;
        end
      end
      reorder_pkg::LAYOUT_1X_1Y2: begin
        tap_used      = (tap_index < 2'h2);
        first_row     = (tap_index == 2'h0) ? 16'h0001 : 16'h0002;
        last_row      = (tap_index == 2'h0) ? h - 16'h0001 : h;
        row_increment = 17'sh00002;
      end
      reorder_pkg::LAYOUT_1X_2YE: begin
        tap_used = (tap_index < 2'h2);
        if (tap_index == 2'h0) begin
          last_row = h2;
        end else begin
          first_row     = h;
          last_row      = h2 + 16'h0001;
          row_increment = -17'sh00001;
        end
      end
      reorder_pkg::LAYOUT_1X3: begin
        tap_used         = (tap_index < 2'h3);
        first_column     = {14'h0000, tap_index} + 16'h0001;
        last_column      = w - 16'h0002 + {14'h0000, tap_index};
        column_increment = 17'sh00003;
      end
      reorder_pkg::LAYOUT_3X: begin
        tap_used     = (tap_index < 2'h3);
        first_column = 16'(w3 * {14'h0000, tap_index}) + 16'h0001;
        last_column  = (tap_index == 2'h2) ? w : 16'(w3 * ({14'h0000, tap_index} + 16'h0001));
      end
      default: begin
      end
    endcase
  end
endmodule
`default_nettype wire

// file: rtl/tap_walker.sv
// Coordinate generator for one tap: steps along a row, then to next row
`timescale 1ns/10ps
`default_nettype none
module tap_walker (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        load,
  input  wire logic        advance,
  input  wire logic [15:0] first_column,
  input  wire logic [15:0] last_column,
  input  wire logic signed [16:0] column_increment,
  input  wire logic [15:0] first_row,
  input  wire logic [15:0] last_row,
  input  wire logic signed [16:0] row_increment,
  output logic      [15:0] column,
  output logic      [15:0] row,
  output logic             finished
);
  typedef struct packed {
    logic [15:0] column;
    logic [15:0] row;
    logic        finished;
  } walk_s;
  walk_s cur;
  walk_s next_cur;

  // Add the signed steps per pixel and per line
  always_comb begin
    next_cur = cur;
    if (load) begin
      next_cur.column   = first_column;
      next_cur.row      = first_row;
      next_cur.finished = 1'b0;
    end else if (advance && !cur.finished) begin
      if (cur.column != last_column) begin
        next_cur.column = 16'($signed({1'b0, cur.column}) + column_increment);
      end else begin
        next_cur.column = first_column;
        if (cur.row == last_row) begin
          next_cur.finished = 1'b1;
        end else begin
          next_cur.row = 16'($signed({1'b0, cur.row}) + row_increment);
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '{column: 16'h0001, row: 16'h0001, finished: 1'b1};
    end else begin
      cur <= next_cur;
    end
  end
  assign column   = cur.column;
  assign row      = cur.row;
  assign finished = cur.finished;
endmodule
`default_nettype wire

// file: rtl/tap_reorder.sv
// Multi-tap pixel reorder core with APB configuration
`timescale 1ns/10ps
`default_nettype none
`include "reorder_cfg.svh"
module tap_reorder (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        frame_start,
  input  wire logic        tap_valid,
  input  wire logic [23:0] tap_data,
  output logic             tap_ready,
  output logic             store_write,
  output logic      [15:0] store_column,
  output logic      [15:0] store_row,
  output logic      [23:0] store_data,
  output logic             frame_done
);
  localparam int NT = `MAX_TAPS;

  typedef struct packed {
    logic                     enable;
    logic                     line_scan;
    logic [1:0]               vantage;
    logic [15:0]              pixels_per_row;
    logic [15:0]              rows_per_frame;
    logic [3:0]               tap_layout_code;
    reorder_pkg::run_state_e  state;
    logic [31:0]              frames;
    logic                     store_write;
    logic [15:0]              store_column;
    logic [15:0]              store_row;
    logic [23:0]              store_data;
    logic                     frame_done;
    logic [31:0]              prdata;
  } core_s;
  core_s cur;
  core_s next_cur;

  logic        load;
  logic        advance;
  logic [15:0] eff_rows;
  logic [15:0] col [NT];
  logic [15:0] row [NT];
  logic [NT-1:0] fin;
  logic [NT-1:0] used;
  logic        all_done;
  logic        wr_acc;
  logic        rd_acc;

  // Number of taps carried by a layout code: zones times taps per zone
  // Codes beyond the table report two taps; they are not supported layouts
  function automatic logic [1:0] layout_taps(input logic [3:0] code);
    case (reorder_pkg::tap_layout_code_e'(code))
      reorder_pkg::LAYOUT_1X:  layout_taps = 2'h1;
      reorder_pkg::LAYOUT_1X3: layout_taps = 2'h3;
      reorder_pkg::LAYOUT_3X:  layout_taps = 2'h3;
      default:                 layout_taps = 2'h2;
    endcase
  endfunction

  // Line-scan frames are one row deep whatever height says
  assign eff_rows = cur.line_scan ? 16'h0001 : cur.rows_per_frame;

  // One descriptor and walker per tap; tap index order follows start row then column
  for (genvar t = 0; t < NT; t++) begin : g_tap
    logic [15:0] fc;
    logic [15:0] lc;
    logic signed [16:0] ci;
    logic [15:0] fr;
    logic [15:0] lr;
    logic signed [16:0] ri;
    tap_descriptor u_desc (
      .tap_layout_code  (cur.tap_layout_code),
      .tap_index        (2'(t)),
      .pixels_per_row   (cur.pixels_per_row),
      .rows_per_frame   (eff_rows),
      .first_column     (fc),
      .last_column      (lc),
      .column_increment (ci),
      .first_row        (fr),
      .last_row         (lr),
      .row_increment    (ri),
      .tap_used         (used[t])
    );
    tap_walker u_walk (
      .pclk             (pclk),
      .presetn          (presetn),
      .load             (load),
      .advance          (advance && used[t]),
      .first_column     (fc),
      .last_column      (lc),
      .column_increment (ci),
      .first_row        (fr),
      .last_row         (lr),
      .row_increment    (ri),
      .column           (col[t]),
      .row              (row[t]),
      .finished         (fin[t])
    );
  end

  // A frame ends when every used tap has walked its last pixel
  assign all_done = &(fin | ~used);
  assign load     = (cur.state != reorder_pkg::RUN_FRAME) && frame_start && cur.enable;
  assign tap_ready = (cur.state == reorder_pkg::RUN_FRAME) && !all_done;
  assign advance  = tap_valid && tap_ready;
  assign wr_acc   = psel && penable && pwrite;
  assign rd_acc   = psel && !penable && !pwrite;

  // Zero-wait APB: always ready, errors never raised
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign prdata  = cur.prdata;

  always_comb begin
    next_cur = cur;
    next_cur.store_write = 1'b0;
    next_cur.frame_done  = 1'b0;
    // Geometry writes during a frame bend the walk; change them between frames
    // Register writes take effect on the access edge
    if (wr_acc) begin
      case (paddr)
        `OFS_CTRL: begin
          next_cur.enable    = pwdata[`CTRL_ENABLE_BIT];
          next_cur.line_scan = pwdata[`CTRL_LINESCAN_BIT];
          next_cur.vantage   = pwdata[`CTRL_VANTAGE_LSB +: 2];
        end
        `OFS_WIDTH:  next_cur.pixels_per_row  = pwdata[15:0];
        `OFS_HEIGHT: next_cur.rows_per_frame  = pwdata[15:0];
        `OFS_LAYOUT: next_cur.tap_layout_code = pwdata[3:0];
        default: begin
        end
      endcase
    end
    // Read data prepared in setup so it is valid during access
    if (rd_acc) begin
      case (paddr)
        `OFS_CTRL:   next_cur.prdata = {28'h0000000, cur.vantage, cur.line_scan, cur.enable};
        `OFS_WIDTH:  next_cur.prdata = {16'h0000, cur.pixels_per_row};
        `OFS_HEIGHT: next_cur.prdata = {16'h0000, cur.rows_per_frame};
        `OFS_STATUS: next_cur.prdata = {cur.frames[23:0], 4'h0, 2'(cur.state),
                                        layout_taps(cur.tap_layout_code)};
        `OFS_LAYOUT: next_cur.prdata = {28'h0000000, cur.tap_layout_code};
        default:     next_cur.prdata = 32'h0000_0000;
      endcase
    end
    // Frame sequencing
    case (cur.state)
      reorder_pkg::RUN_IDLE, reorder_pkg::RUN_DONE: begin
        if (load) begin
          next_cur.state = reorder_pkg::RUN_FRAME;
        end
      end
      reorder_pkg::RUN_FRAME: begin
        if (all_done) begin
          next_cur.state      = reorder_pkg::RUN_DONE;
          next_cur.frame_done = 1'b1;
          next_cur.frames     = cur.frames + 32'h0000_0001;
        end
      end
      default: next_cur.state = reorder_pkg::RUN_IDLE;
    endcase
    // Place the pixel at the current coordinate of tap one (index 0)
    if (advance) begin
      next_cur.store_write  = 1'b1;
      next_cur.store_data   = tap_data;
      next_cur.store_column = col[0];
      next_cur.store_row    = row[0];
      // Mirror after placement so pixel one,one lands in the chosen corner
      if (cur.vantage[0]) begin
        next_cur.store_column = cur.pixels_per_row + 16'h0001 - col[0];
      end
      if (cur.vantage[1] && !cur.line_scan) begin
        next_cur.store_row = eff_rows + 16'h0001 - row[0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '{enable: 1'b0, line_scan: 1'b0,
               vantage: 2'(reorder_pkg::VANTAGE_TOP_LEFT),
               pixels_per_row: `WIDTH_RESET, rows_per_frame: `HEIGHT_RESET,
               tap_layout_code: `LAYOUT_RESET, state: reorder_pkg::RUN_IDLE,
               frames: 32'h0000_0000, store_write: 1'b0, store_column: 16'h0000,
               store_row: 16'h0000, store_data: 24'h000000, frame_done: 1'b0,
               prdata: 32'h0000_0000};
    end else begin
      cur <= next_cur;
    end
  end

  assign store_write  = cur.store_write;
  assign store_column = cur.store_column;
  assign store_row    = cur.store_row;
  assign store_data   = cur.store_data;
  assign frame_done   = cur.frame_done;

  // Pixel placement: each accepted pixel is written once, one cycle later
  chk_store_follows_accept: assert property (@(posedge pclk) disable iff (!presetn)
    advance |=> store_write)
    else $error("store write missing after accepted pixel");
  chk_no_store_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !advance |=> !store_write)
    else $error("store write without accepted pixel");
  chk_data_passes: assert property (@(posedge pclk) disable iff (!presetn)
    advance |=> store_data == $past(tap_data))
    else $error("stored data differs from accepted pixel");

  // Settings: reset corner, register writes, line-scan depth
  chk_default_vantage_tl: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> cur.vantage == 2'h0)
    else $error("vantage not top-left after reset");
  chk_vantage_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == `OFS_CTRL) |=> cur.vantage == $past(pwdata[`CTRL_VANTAGE_LSB +: 2]))
    else $error("vantage write lost");
  chk_width_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == `OFS_WIDTH) |=> cur.pixels_per_row == $past(pwdata[15:0]))
    else $error("width write lost");
  chk_linescan_one_row: assert property (@(posedge pclk) disable iff (!presetn)
    (advance && cur.line_scan) |=> store_row == 16'h0001)
    else $error("line-scan row not one");

  // Corner mapping on both axes
  chk_mirror_column_map: assert property (@(posedge pclk) disable iff (!presetn)
    (advance && cur.vantage[0]) |=> store_column == cur.pixels_per_row + 16'h0001 - $past(col[0]))
    else $error("horizontal mirror wrong");
  chk_plain_column_map: assert property (@(posedge pclk) disable iff (!presetn)
    (advance && !cur.vantage[0]) |=> store_column == $past(col[0]))
    else $error("column placement wrong");
  chk_mirror_row_map: assert property (@(posedge pclk) disable iff (!presetn)
    (advance && cur.vantage[1] && !cur.line_scan) |=>
      store_row == eff_rows + 16'h0001 - $past(row[0]))
    else $error("vertical mirror wrong");
  chk_plain_row_map: assert property (@(posedge pclk) disable iff (!presetn)
    (advance && !cur.vantage[1]) |=> store_row == $past(row[0]))
    else $error("row placement wrong");

  // Walk of tap one: signed step along a row, then back to its first column
  chk_column_step: assert property (@(posedge pclk) disable iff (!presetn)
    (advance && !fin[0] && col[0] != g_tap[0].lc) |=>
      col[0] == 16'($signed({1'b0, $past(col[0])}) + $past(g_tap[0].ci)))
    else $error("column step wrong");
  chk_row_step: assert property (@(posedge pclk) disable iff (!presetn)
    (advance && !fin[0] && col[0] == g_tap[0].lc && row[0] != g_tap[0].lr) |=>
      (row[0] == 16'($signed({1'b0, $past(row[0])}) + $past(g_tap[0].ri)) &&
       col[0] == g_tap[0].fc))
    else $error("row step wrong");

  // Tap numbering follows start row, then start column
  chk_tap_order_second: assert property (@(posedge pclk) disable iff (!presetn)
    load |=> (!used[1] || row[0] < row[1] || (row[0] == row[1] && col[0] < col[1])))
    else $error("tap two starts before tap one");
  chk_tap_order_third: assert property (@(posedge pclk) disable iff (!presetn)
    load |=> (!used[2] || row[1] < row[2] || (row[1] == row[2] && col[1] < col[2])))
    else $error("tap three starts before tap two");
  chk_start_at_first: assert property (@(posedge pclk) disable iff (!presetn)
    (load && cur.tap_layout_code == 4'h0) |=> (col[0] == 16'h0001 && row[0] == 16'h0001))
    else $error("walk did not start at one,one");

  // Frame sequencing
  chk_done_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    frame_done |=> !frame_done)
    else $error("frame done longer than one cycle");
  chk_done_when_walked: assert property (@(posedge pclk) disable iff (!presetn)
    (cur.state == reorder_pkg::RUN_FRAME && all_done) |=> frame_done)
    else $error("frame done missing after last pixel");
  chk_no_ready_outside: assert property (@(posedge pclk) disable iff (!presetn)
    (cur.state != reorder_pkg::RUN_FRAME) |-> !tap_ready)
    else $error("ready outside frame");
  chk_taps_end_together: assert property (@(posedge pclk) disable iff (!presetn)
    (cur.state == reorder_pkg::RUN_FRAME && fin[0]) |-> all_done)
    else $error("taps did not finish together");
  chk_frame_counted: assert property (@(posedge pclk) disable iff (!presetn)
    frame_done |-> cur.frames == $past(cur.frames) + 32'h0000_0001)
    else $error("frame count not advanced");
endmodule
`default_nettype wire

// file: bench/tap_camera_model.sv
// Behavioural multi-tap camera output feeding the first tap's pixel stream
`timescale 1ns/10ps
`default_nettype none
module tap_camera_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        load,
  input  wire logic [15:0] count,
  input  wire logic        slow,
  input  wire logic        tap_ready,
  output logic             tap_valid,
  output logic      [23:0] tap_data
);
  logic [15:0] left;
  logic [23:0] seq;

  // Fixed pixel count per frame, same for every tap; pixel k carries k+1
  // Idle data toggles so a stale value is never mistaken for a fresh pixel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left      <= 16'h0000;
      seq       <= 24'h000000;
      tap_valid <= 1'b0;
      tap_data  <= 24'h000000;
    end else if (load) begin
      left      <= count;
      seq       <= 24'h000000;
      tap_valid <= 1'b0;
      tap_data  <= ~tap_data;
    end else if (tap_valid && tap_ready) begin
      left <= left - 16'h0001;
      seq  <= seq + 24'h000001;
      // Slow mode drops valid for a cycle between pixels
      if (slow || left == 16'h0001) begin
        tap_valid <= 1'b0;
        tap_data  <= ~tap_data;
      end else begin
        tap_data <= seq + 24'h000002;
      end
    end else if (!tap_valid && left != 16'h0000) begin
      tap_valid <= 1'b1;
      tap_data  <= seq + 24'h000001;
    end else if (!tap_valid) begin
      tap_data <= ~tap_data;
    end
  end
endmodule
`default_nettype wire

// file: bench/tb_tap_reorder.sv
// Self-checking bench for the tap reorder core
`timescale 1ns/10ps
`default_nettype none
`include "reorder_cfg.svh"
module tb_tap_reorder;
  localparam int W = 12;
  localparam int H = 4;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, frame_start, tap_valid, tap_ready;
  logic [23:0] tap_data, store_data;
  logic        store_write, frame_done, load, slow;
  logic [15:0] store_column, store_row, cam_n;
  logic [55:0] eq[$];
  int          errors, n_checks, nf;

  tap_reorder DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frame_start(frame_start), .tap_valid(tap_valid),
    .tap_data(tap_data), .tap_ready(tap_ready), .store_write(store_write),
    .store_column(store_column), .store_row(store_row), .store_data(store_data),
    .frame_done(frame_done));

  tap_camera_model cam (.pclk(pclk), .presetn(presetn), .load(load), .count(cam_n),
    .slow(slow), .tap_ready(tap_ready), .tap_valid(tap_valid), .tap_data(tap_data));

  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [55:0] got, input logic [55:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 50) begin
      errors++;
      end_sim();
    end
    chk(56'(pslverr), 56'h0);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Every stored pixel must match the next expected placement of tap one
  always @(posedge pclk) begin
    if (store_write === 1'b1) begin
      if (eq.size() == 0) begin
        chk({store_column, store_row, store_data}, 56'h0);
      end else begin
        chk({store_column, store_row, store_data}, eq.pop_front());
      end
    end
  end

  // Builds the expected tap-one walk, then runs one frame through the core
  task automatic run(input logic [3:0] lay, input logic [1:0] v, input logic ls,
                     input logic sl);
    int fc, lc, ci, fr, lr, ri, hh, n, c, r, k;
    hh = ls ? 1 : H;
    fc = 1; lc = W; ci = 1; fr = 1; lr = hh; ri = 1;
    case (lay)
      4'h1: begin lc = W - 1; ci = 2; end
      4'h2, 4'h3: lc = W / 2;
      4'h4: begin fc = W / 2; lc = 1; ci = -1; end
      4'h5: begin lr = H - 1; ri = 2; end
      4'h6: lr = H / 2;
      4'h7: begin lc = W - 2; ci = 3; end
      4'h8: lc = W / 3;
      default: ;
    endcase
    n = 0;
    for (r = fr; r != lr + ri; r += ri) begin
      for (c = fc; c != lc + ci; c += ci) begin
        eq.push_back({16'(v[0] ? W + 1 - c : c), 16'(v[1] ? hh + 1 - r : r), 24'(n + 1)});
        n++;
      end
    end
    apb(1'b1, 12'h010, {28'h0, lay});
    apb(1'b1, 12'h000, {28'h0, v, ls, 1'b1});
    @(posedge pclk);
    cam_n       <= 16'(n);
    slow        <= sl;
    load        <= 1'b1;
    frame_start <= 1'b1;
    @(posedge pclk);
    load        <= 1'b0;
    frame_start <= 1'b0;
    for (k = 0; k < 2000; k++) begin
      @(posedge pclk);
      if (frame_done === 1'b1) break;
    end
    if (k == 2000) begin
      errors++;
      end_sim();
    end
    repeat (2) @(posedge pclk);
    chk(56'(eq.size()), 56'h0);
    chk(56'(tap_ready), 56'h0);
    // Status: tap count of the layout, done state and frame count
    nf++;
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(56'(q[1:0]), 56'((lay == 4'h0) ? 1 : ((lay > 4'h6) ? 3 : 2)));
    chk(56'(q[31:2]), 56'({nf[23:0], 6'h02}));
    $display("Test layout %0d vantage %0d line %0d done", lay, v, ls);
  endtask

  initial begin
    errors = 0;
    n_checks = 0;
    nf = 0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; frame_start = 1'b0;
    load = 1'b0; slow = 1'b0; cam_n = 16'h0000;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, default corner and an unmapped read
    apb(1'b0, 12'h000, 32'h0);
    chk(56'(q[3:2]), 56'h0);
    apb(1'b0, 12'h004, 32'h0);
    chk(56'(q), 56'(`WIDTH_RESET));
    apb(1'b0, 12'h008, 32'h0);
    chk(56'(q), 56'(`HEIGHT_RESET));
    apb(1'b0, 12'h010, 32'h0);
    chk(56'(q), 56'h0);
    apb(1'b0, 12'h014, 32'h0);
    chk(56'(q), 56'h0);
    apb(1'b1, 12'h004, 32'(W));
    apb(1'b1, 12'h008, 32'(H));
    apb(1'b0, 12'h004, 32'h0);
    chk(56'(q), 56'(W));
    $display("Test registers done");
    // Every supported layout, top-left corner
    for (int i = 0; i < 9; i++) begin
      run(4'(i), 2'h0, 1'b0, 1'b0);
    end
    // Mirrored corners with a stalling camera
    for (int i = 1; i < 4; i++) begin
      run(4'h4, 2'(i), 1'b0, 1'b1);
    end
    // Line-scan: height setting must be ignored
    apb(1'b1, 12'h008, 32'h7);
    run(4'h0, 2'h0, 1'b1, 1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
